/* hw/flash_upgrade_and_reload_port_regs.vh */
// Constants of the flash upgrade and reload port.
//
// Contract
// - Flash writes allowed only while guard bit is zero.
// - Written byte is shifted serially to flash.
// - Reload write: soft reset, ROM reload, PLL reconfigure.
// - Power-on starts with the event buffer emptied.
// - Power-on loads registers with default values.
// - Boot image chosen by selection jumper at power-on.
// - Firmware replaced by host writes to flash.
// - Software reset location performs a software reset.
`ifndef FLASH_UPGRADE_AND_RELOAD_PORT_REGS_VH
`define FLASH_UPGRADE_AND_RELOAD_PORT_REGS_VH

// ****************************************************************
// Register offsets
// ****************************************************************
`define SOFT_RESET_OFS 16'hEF24
`define FLASH_WRITE_GUARD_OFS 16'hEF2C
`define FLASH_SERIAL_BYTE_OFS 16'hEF30
`define CONFIG_RELOAD_TRIGGER_OFS 16'hEF34

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define GUARD_BIT 0
`define GUARD_RST 1'h1
`define BYTE_RST 8'h00

// ****************************************************************
// Timing
// ****************************************************************
`define SPI_HALF_CYCLES 4'h2
`define SYNC_FILL 2'h3

`endif

/* hw/flash_upgrade_and_reload_port.v */
// Flash upgrade, serial byte port and configuration reload control.
`timescale 1ns/1ps
`include "flash_upgrade_and_reload_port_regs.vh"

module flash_upgrade_and_reload_port (
  input wire clock,
  input wire arst_n,
  input wire clock_en,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata,
  input wire reg_wr,
  input wire reg_rd,
  output reg [31:0] reg_rdata,
  output reg flash_sck,
  output reg flash_mosi,
  output wire flash_cs_n,
  input wire flash_miso,
  output wire flash_busy,
  output reg soft_reset,
  output reg rom_reload,
  output reg pll_reconfig,
  output reg event_buffer_clear,
  input wire image_select_jumper,
  output reg boot_image_backup,
  output reg boot_load_start
);

  // ****************************************************************
  // States
  // ****************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_SHIFT = 2'b10;
  // The serial clock spends HALF system clocks in each level.
  localparam [3:0] HALF = `SPI_HALF_CYCLES;

  reg [1:0] state_reg;
  reg [1:0] state_next;
  reg guard_reg;
  reg [7:0] tx_reg;
  reg [7:0] rx_reg;
  reg [2:0] bit_cnt_reg;
  reg [3:0] div_reg;
  reg [2:0] miso_sync_reg;
  reg [2:0] jump_sync_reg;
  reg miso_val_reg;
  reg boot_done_reg;
  reg miso_hold_reg;
  reg [1:0] sync_fill_reg;

  wire wr_guard;
  wire wr_byte;
  wire wr_soft;
  wire wr_reload;
  wire any_soft;
  wire half_done;
  wire miso_agree;
  wire miso_clean;

  assign wr_guard = reg_wr && (reg_addr == `FLASH_WRITE_GUARD_OFS);
  assign wr_byte = reg_wr && (reg_addr == `FLASH_SERIAL_BYTE_OFS);
  assign wr_soft = reg_wr && (reg_addr == `SOFT_RESET_OFS);
  assign wr_reload = reg_wr && (reg_addr == `CONFIG_RELOAD_TRIGGER_OFS);
  assign any_soft = wr_soft || wr_reload;
  assign half_done = (div_reg == HALF - 4'h1);
  // Chip select follows the guard so a locked flash sees no commands.
  assign flash_cs_n = guard_reg;
  assign flash_busy = state_reg[1];

  // ****************************************************************
  // Next state
  // ****************************************************************
  always @* begin
    state_next = state_reg;
    case (state_reg)
      ST_IDLE: begin
        if (wr_byte && !guard_reg && !any_soft) begin
          state_next = ST_SHIFT;
        end
      end
      ST_SHIFT: begin
        // A reset in mid-byte abandons it; the host must send it again.
        if (any_soft) begin
          state_next = ST_IDLE;
        end else if (half_done && flash_sck && bit_cnt_reg == 3'h7) begin
          state_next = ST_IDLE;
        end
      end
      default: begin
        state_next = ST_IDLE;
      end
    endcase
  end

  // ****************************************************************
  // Registers and serial engine
  // ****************************************************************
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      state_reg <= ST_IDLE;
      guard_reg <= `GUARD_RST;
      tx_reg <= `BYTE_RST;
      rx_reg <= `BYTE_RST;
      bit_cnt_reg <= 3'h0;
      div_reg <= 4'h0;
      flash_sck <= 1'b0;
      flash_mosi <= 1'b0;
      miso_val_reg <= 1'b0;
      reg_rdata <= 32'h0000_0000;
      soft_reset <= 1'b0;
      rom_reload <= 1'b0;
      pll_reconfig <= 1'b0;
      event_buffer_clear <= 1'b1;
    end else if (clock_en) begin
      state_reg <= state_next;
      event_buffer_clear <= 1'b0;
      soft_reset <= any_soft;
      rom_reload <= wr_reload;
      pll_reconfig <= wr_reload;
      if (any_soft) begin
        // A cut byte parks the data line low, as on an idle bus.
        guard_reg <= `GUARD_RST;
        flash_sck <= 1'b0;
        flash_mosi <= 1'b0;
        div_reg <= 4'h0;
      end else begin
        if (wr_guard) begin
          guard_reg <= reg_wdata[`GUARD_BIT];
        end
        if (state_reg == ST_IDLE && state_next == ST_SHIFT) begin
          tx_reg <= {reg_wdata[6:0], 1'b0};
          flash_mosi <= reg_wdata[7];
          bit_cnt_reg <= 3'h0;
          div_reg <= 4'h0;
          flash_sck <= 1'b0;
        end else if (state_reg == ST_SHIFT) begin
          div_reg <= half_done ? 4'h0 : div_reg + 4'h1;
          if (half_done) begin
            flash_sck <= ~flash_sck;
            if (flash_sck) begin
              flash_mosi <= tx_reg[7];
              tx_reg <= {tx_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 3'h1;
              if (bit_cnt_reg == 3'h7) begin
                flash_mosi <= 1'b0;
              end
            end else begin
              miso_val_reg <= 1'b1;
            end
          end
          // Sample the synchronised data a half period after the edge,
          // which covers the three-flop latency of the input path.
          if (miso_val_reg && half_done && flash_sck) begin
            rx_reg <= {rx_reg[6:0], miso_clean};
            miso_val_reg <= 1'b0;
          end
        end
      end
      // Reads of the byte register return what the flash sent back, so
      // status bytes come through the same port as the written ones.
      if (reg_rd) begin
        case (reg_addr)
          `FLASH_WRITE_GUARD_OFS: reg_rdata <= {31'h0, guard_reg};
          `FLASH_SERIAL_BYTE_OFS: reg_rdata <= {24'h0, rx_reg};
          default: reg_rdata <= 32'h0000_0000;
        endcase
      end
    end
  end

  // ****************************************************************
  // Serial input synchroniser
  // ****************************************************************
  // A level counts only once the last two stages agree, so a disturbed
  // first stage never reaches the received byte.
  assign miso_agree = (miso_sync_reg[2] == miso_sync_reg[1]);
  assign miso_clean = miso_agree ? miso_sync_reg[2] : miso_hold_reg;

  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      miso_sync_reg <= 3'h0;
      miso_hold_reg <= 1'b0;
    end else if (clock_en) begin
      miso_sync_reg <= {miso_sync_reg[1:0], flash_miso};
      miso_hold_reg <= miso_clean;
    end
  end

  // ****************************************************************
  // Jumper synchroniser and boot image selection
  // ****************************************************************
  // The fill count keeps the reset contents of the chain from being
  // taken for a jumper setting.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      jump_sync_reg <= 3'h0;
      sync_fill_reg <= 2'h0;
    end else if (clock_en) begin
      jump_sync_reg <= {jump_sync_reg[1:0], image_select_jumper};
      if (sync_fill_reg != `SYNC_FILL) begin
        sync_fill_reg <= sync_fill_reg + 2'h1;
      end
    end
  end

  // One start pulse per reset; a later jumper move waits for a reset.
  always @(posedge clock or negedge arst_n) begin
    if (!arst_n) begin
      boot_image_backup <= 1'b0;
      boot_load_start <= 1'b0;
      boot_done_reg <= 1'b0;
    end else if (clock_en) begin
      boot_load_start <= 1'b0;
      // The jumper is caught once, after the synchroniser has filled.
      if (!boot_done_reg && sync_fill_reg == `SYNC_FILL &&
          jump_sync_reg[2] == jump_sync_reg[1]) begin
        boot_image_backup <= jump_sync_reg[2];
        boot_load_start <= 1'b1;
        boot_done_reg <= 1'b1;
      end
    end
  end

endmodule // flash_upgrade_and_reload_port

/* bench/flash_port_checker_assertions.sv */
// Assertion checker of the flash port.
`timescale 1ns/1ps
`include "flash_upgrade_and_reload_port_regs.vh"
module flash_port_checker (
  input wire clock,
  input wire arst_n,
  input wire clock_en,
  input wire reg_wr,
  input wire flash_sck,
  input wire flash_mosi,
  input wire flash_cs_n,
  input wire flash_busy,
  input wire soft_reset,
  input wire rom_reload,
  input wire pll_reconfig,
  input wire image_select_jumper,
  input wire boot_image_backup,
  input wire boot_load_start,
  input wire [15:0] reg_addr,
  input wire [31:0] reg_wdata
);
  wire wr = reg_wr && clock_en;
  wire wb = wr && reg_addr == `FLASH_SERIAL_BYTE_OFS;
  default clocking @(posedge clock); endclocking
  default disable iff (!arst_n);
  a_guard_blocks: assert property (
    wb && flash_cs_n && !flash_busy |=> !flash_busy) else $error("guard");
  a_byte_msb: assert property (wb && !flash_cs_n && !flash_busy |=>
    flash_busy && flash_mosi == $past(reg_wdata[7])) else $error("msb");
  a_reload_pulses: assert property (
    wr && reg_addr == `CONFIG_RELOAD_TRIGGER_OFS |=> soft_reset &&
    rom_reload && pll_reconfig && flash_cs_n) else $error("reload");
  a_soft_only: assert property (wr && reg_addr == `SOFT_RESET_OFS |=>
    soft_reset && !rom_reload) else $error("soft reset");
  a_idle_lines: assert property (
    !flash_busy |-> !flash_sck && !flash_mosi) else $error("idle");
  a_byte_length: assert property ($rose(flash_busy) |->
    flash_busy[*8] ##[20:30] !flash_busy) else $error("length");
  a_sck_high: assert property (
    $rose(flash_sck) |=> flash_sck || soft_reset) else $error("sck");
  a_boot_choice: assert property (boot_load_start |->
    boot_image_backup == image_select_jumper) else $error("boot");
  cover property (wb && !flash_cs_n);
  cover property (rom_reload);
  cover property (boot_load_start);
  cover property (flash_busy ##1 soft_reset);
endmodule // flash_port_checker
bind flash_upgrade_and_reload_port flash_port_checker u_flash_port_checker (.*);

/* bench/flash_spi_model.sv */
// Behavioural model of the serial configuration flash.
`timescale 1ns/1ps
module flash_spi_model #(parameter logic [7:0] TX = 8'h3C) (
  input wire sck,
  input wire mosi,
  input wire cs_n,
  output wire miso,
  output logic [7:0] rx_byte = 8'h00
);
  logic [2:0] bitn = 3'h0;
  always @(posedge sck) rx_byte <= {rx_byte[6:0], mosi};
  always @(negedge sck or posedge cs_n) bitn <= cs_n ? 3'h0 : bitn + 3'h1;
  // Deselected, the line shows the inverse of the last bit received on mosi.
  assign miso = cs_n ? ~rx_byte[0] : TX[3'h7 - bitn];
endmodule // flash_spi_model

/* bench/flash_upgrade_and_reload_port_tb.sv */
// Self-checking testbench of the flash upgrade and reload port.
`timescale 1ns/1ps
`include "flash_upgrade_and_reload_port_regs.vh"
module flash_upgrade_and_reload_port_tb;
  logic clock = 1'b0, arst_n = 1'b0, clock_en = 1'b1, reg_wr = 1'b0;
  logic reg_rd = 1'b0, image_select_jumper = 1'b1;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0, reg_rdata, d;
  wire flash_sck, flash_mosi, flash_cs_n, flash_miso, flash_busy, soft_reset;
  wire rom_reload, pll_reconfig, event_buffer_clear, boot_image_backup;
  wire boot_load_start;
  wire [7:0] rx_byte;
  int mismatches = 0;
  int n_checks = 0;
  always #4 clock = ~clock;
  flash_upgrade_and_reload_port u_flash_upgrade_and_reload_port (.*);
  flash_spi_model u_flash_spi_model (.sck(flash_sck), .mosi(flash_mosi),
    .cs_n(flash_cs_n), .miso(flash_miso), .rx_byte(rx_byte));
  task automatic chk(input string what, input logic [31:0] exp, got);
    n_checks++;
    if (got !== exp) begin
      mismatches++;
      $display("[ERR] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= v;
    reg_wr <= 1'b1;
    @(posedge clock);
    reg_wr <= 1'b0;
    #1;
  endtask
  task automatic rd(input logic [15:0] a);
    @(posedge clock);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge clock);
    reg_rd <= 1'b0;
    #1;
    d = reg_rdata;
  endtask
  task automatic t_power_on();
    @(posedge clock);
    #1;
    chk("clear", 1, event_buffer_clear);
    chk("cs", 1, flash_cs_n);
    @(posedge clock);
    arst_n <= 1'b1;
    repeat (8) @(posedge clock);
    rd(`FLASH_WRITE_GUARD_OFS);
    chk("guard", `GUARD_RST, d);
    chk("image", 1, boot_image_backup);
    chk("clear", 0, event_buffer_clear);
  endtask
  task automatic t_byte();
    int n = 0;
    wr(`FLASH_SERIAL_BYTE_OFS, 32'h5A);
    chk("busy", 0, flash_busy);
    wr(`FLASH_WRITE_GUARD_OFS, 32'h0);
    wr(`FLASH_SERIAL_BYTE_OFS, 32'hA5);
    chk("busy", 1, flash_busy);
    while (n < 100 && flash_busy) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("byte", 8'hA5, rx_byte);
    chk("byte cycles", 16 * `SPI_HALF_CYCLES, n);
    chk("idle lines", 0, {flash_sck, flash_mosi, flash_busy});
    rd(`FLASH_SERIAL_BYTE_OFS);
    chk("miso byte", 8'h3C, d);
  endtask
  task automatic t_reload();
    logic [2:0] snap;
    wr(`FLASH_SERIAL_BYTE_OFS, 32'hC3);
    repeat (12) @(posedge clock);
    clock_en <= 1'b0;
    #1;
    snap = {flash_sck, flash_mosi, flash_busy};
    repeat (5) @(posedge clock);
    clock_en <= 1'b1;
    #1;
    chk("freeze", snap, {flash_sck, flash_mosi, flash_busy});
    wr(`CONFIG_RELOAD_TRIGGER_OFS, 32'hFFFF_FFFF);
    chk("pulses", 3'h7, {soft_reset, rom_reload, pll_reconfig});
    chk("abort", 0, {flash_sck, flash_mosi, flash_busy});
    rd(`FLASH_WRITE_GUARD_OFS);
    chk("guard", 1, d);
    chk("pulse end", 0, {soft_reset, rom_reload, pll_reconfig});
  endtask
  task automatic t_soft_reset();
    wr(`FLASH_WRITE_GUARD_OFS, 32'h0);
    wr(`SOFT_RESET_OFS, 32'h0);
    chk("soft", 3'h4, {soft_reset, rom_reload, pll_reconfig});
    rd(`FLASH_WRITE_GUARD_OFS);
    chk("guard", 1, d);
    rd(16'hEF38);
    chk("unmapped", 0, d);
  endtask
  task automatic t_reboot();
    int n = 0;
    @(posedge clock);
    image_select_jumper <= 1'b0;
    arst_n <= 1'b0;
    repeat (2) @(posedge clock);
    #1;
    chk("clear", 1, event_buffer_clear);
    chk("cs", 1, flash_cs_n);
    @(posedge clock);
    arst_n <= 1'b1;
    while (n < 20 && !boot_load_start) begin
      @(posedge clock);
      #1;
      n++;
    end
    chk("boot start", 1, boot_load_start);
    chk("image", 0, boot_image_backup);
    chk("boot delay", 4, n);
    chk("clear", 0, event_buffer_clear);
    @(posedge clock);
    #1;
    chk("boot pulse", 0, boot_load_start);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask
  // Whole run is about a hundred cycles; the limit leaves wide margin.
  initial begin
    #100000;
    mismatches++;
    final_report();
  end
  initial begin
    t_power_on();
    t_byte();
    t_reload();
    t_soft_reset();
    t_reboot();
    final_report();
  end
endmodule // flash_upgrade_and_reload_port_tb
